// *** inc/pri_pkg.sv ***
// constants, types and decode helpers for the pmic two-wire register port
package pri_pkg;

  // target address options, selected by the addr_sel strap pin, sampled continuously
  localparam logic [6:0] TGT_ADDR_STRAP1 = 7'h48;
  localparam logic [6:0] TGT_ADDR_STRAP0 = 7'h40;
  localparam logic [4:0] HS_CODE_PFX     = 5'h01;
  localparam logic [7:0] GCALL_ADDR      = 8'h00;
  localparam logic [3:0] BYTE_BITS       = 4'h8;
  localparam logic [3:0] CNT_ZERO        = 4'h0;
  localparam logic [7:0] PTR_STEP        = 8'h01;
  localparam logic       SDA_DRIVE_LVL   = 1'b0;
  localparam logic       PIN_IDLE        = 1'b1;

  // input spike suppression, in ns, converted to mclk samples
  localparam int         CLK_FREQ_MHZ  = 50;
  localparam int         CLK_PERIOD_NS = 1000 / CLK_FREQ_MHZ;
  localparam int         SPK_LS_NS     = 40;
  localparam int         SPK_HS_NS     = 10;
  localparam int         SPK_LS_RAW    = SPK_LS_NS / CLK_PERIOD_NS;
  localparam int         SPK_HS_RAW    = SPK_HS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] SPK_LS_CYC = 4'((SPK_LS_RAW < 1) ? 1 : SPK_LS_RAW);
  localparam logic [3:0] SPK_HS_CYC = 4'((SPK_HS_RAW < 1) ? 1 : SPK_HS_RAW);

  // register map
  localparam int         RW_N   = 16;
  localparam int         RC_N   = 4;
  localparam int         RO_N   = 4;
  localparam logic [7:0] RW_RST = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  localparam logic [7:0] RW_OFS [RW_N] = '{
    8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12, 8'h13, 8'h17,
    8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27};
  // event flags: global_a, charger, global_b, reset cause
  localparam logic [7:0] RC_OFS [RC_N] = '{8'h00, 8'h01, 8'h04, 8'h05};
  // status: charger_a, charger_b, global, chip identity
  localparam logic [7:0] RO_OFS [RO_N] = '{8'h02, 8'h03, 8'h06, 8'h14};

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_PTR  = 3'b010,
    ST_WDAT = 3'b011,
    ST_RDAT = 3'b100,
    ST_SKIP = 3'b101
  } pri_state_t;

  function automatic logic [4:0] rw_slot(input logic [7:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < RW_N; i++) begin
      if (a == RW_OFS[i]) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] small_slot(input logic [7:0] a,
                                            input logic [31:0] ofs);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (a == ofs[i*8 +: 8]) begin
        r = {1'b1, 2'(i)};
      end
    end
    return r;
  endfunction

endpackage

// *** inc/pri_reg_if.sv ***
// register access path between protocol engine and register bank
`timescale 1ns/10ps
interface pri_reg_if;
  logic [7:0] addr;
  logic       wr_en;
  logic [7:0] wr_data;
  logic       rd_en;
  logic [7:0] rd_data;
  modport eng  (output addr, output wr_en, output wr_data, output rd_en,
                input rd_data);
  modport bank (input addr, input wr_en, input wr_data, input rd_en,
                output rd_data);
endinterface

// *** rtl/pri_i2c_target.sv ***
// two-wire target port giving byte access to the register bank
`timescale 1ns/10ps
module pri_i2c_target
  import pri_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A  // value arbitrary
) (
  input  wire logic                mclk,
  input  wire logic                srst,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output logic                     sda_o,
  output logic                     sda_oe,
  input  wire logic                addr_sel,
  output logic                     hs_filter,
  input  wire logic [RC_N*8-1:0]   ev_flags,
  input  wire logic [23:0]         st_in,
  output logic      [RW_N*8-1:0]   cfg_out
);
  pri_reg_if rb ();

  logic [2:0]  pins_f;
  logic        scl_f;
  logic        sda_f;
  logic        sel_f;
  logic        scl_p_q;
  logic        sda_p_q;

  pri_state_t  state_q;
  pri_state_t  state_d;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic        ack_q;
  logic        ack_d;
  logic [7:0]  sr_q;
  logic [7:0]  sr_d;
  logic [7:0]  tx_q;
  logic [7:0]  tx_d;
  logic [7:0]  ptr_q;
  logic [7:0]  ptr_d;
  logic        hs_q;
  logic        hs_d;
  logic        oe_q;
  logic        oe_d;
  logic        mack_q;
  logic        mack_d;
  logic        wr_en;
  logic        rd_en;

  // pins pass two flops and the spike filter before use
  pri_sync #(
    .W (3)
  ) u_sync (
    .mclk   (mclk),
    .srst   (srst),
    .d_in   ({addr_sel, sda_i, scl_i}),
    .hs_sel (hs_q),
    .d_out  (pins_f)
  );

  assign scl_f = pins_f[0];
  assign sda_f = pins_f[1];
  assign sel_f = pins_f[2];

  pri_regbank #(
    .CHIP_ID (CHIP_ID)
  ) u_bank (
    .mclk     (mclk),
    .srst     (srst),
    .rb       (rb.bank),
    .ev_flags (ev_flags),
    .st_in    (st_in),
    .cfg_out  (cfg_out)
  );

  // bus condition decode
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl_f & ~scl_p_q;
  assign scl_fall = ~scl_f & scl_p_q;
  assign start_c  = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_c   = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // received byte decode
  logic [6:0] own_addr;
  logic       adr_match;
  logic       is_hs_code;
  logic       is_gcall;
  logic       give_ack;
  logic       byte_fall;
  logic       ack_end;
  logic       rx_state;
  assign own_addr   = sel_f ? TGT_ADDR_STRAP1 : TGT_ADDR_STRAP0;
  assign adr_match  = (sr_q[7:1] == own_addr);
  assign is_hs_code = (sr_q[7:3] == HS_CODE_PFX);
  assign is_gcall   = (sr_q == GCALL_ADDR);
  // pointer and data bytes are always acknowledged
  assign give_ack   = (state_q != ST_ADDR) ||
                      (adr_match && !is_gcall);
  assign byte_fall  = scl_fall && (cnt_q == BYTE_BITS) && !ack_q;
  assign ack_end    = scl_fall && ack_q;
  assign rx_state   = (state_q == ST_ADDR) || (state_q == ST_PTR) ||
                      (state_q == ST_WDAT);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ack_d   = ack_q;
    sr_d    = sr_q;
    tx_d    = tx_q;
    ptr_d   = ptr_q;
    hs_d    = hs_q;
    oe_d    = oe_q;
    mack_d  = mack_q;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    if (stop_c) begin
      state_d = ST_IDLE;
      hs_d    = 1'b0;
      oe_d    = 1'b0;
      cnt_d   = CNT_ZERO;
      ack_d   = 1'b0;
    end else if (start_c) begin
      // repeated start leaves filter choice alone
      state_d = ST_ADDR;
      oe_d    = 1'b0;
      cnt_d   = CNT_ZERO;
      ack_d   = 1'b0;
    end else if (rx_state) begin
      if (scl_rise && cnt_q < BYTE_BITS) begin
        sr_d  = {sr_q[6:0], sda_f};
        cnt_d = cnt_q + 4'h1;
      end else if (byte_fall) begin
        ack_d = 1'b1;
        oe_d  = give_ack;
        if (state_q == ST_ADDR && is_hs_code) begin
          hs_d = 1'b1;
        end
      end else if (ack_end) begin
        ack_d = 1'b0;
        cnt_d = CNT_ZERO;
        oe_d  = 1'b0;
        case (state_q)
          ST_ADDR: begin
            if (!oe_q) begin
              state_d = ST_SKIP;
            end else if (sr_q[0]) begin
              state_d = ST_RDAT;
              tx_d    = rb.rd_data;
              oe_d    = ~rb.rd_data[7];
              rd_en   = 1'b1;
              mack_d  = 1'b1;
            end else begin
              state_d = ST_PTR;
            end
          end
          ST_PTR: begin
            ptr_d   = sr_q;
            state_d = ST_WDAT;
          end
          ST_WDAT: begin
            // commit as the line is released after the ack slot
            wr_en = 1'b1;
            ptr_d = ptr_q + PTR_STEP;
          end
          default: begin
            state_d = ST_IDLE;
          end
        endcase
      end
    end else if (state_q == ST_RDAT) begin
      if (scl_rise) begin
        if (cnt_q < BYTE_BITS) begin
          cnt_d = cnt_q + 4'h1;
        end else begin
          mack_d = sda_f;
          if (!sda_f) begin
            ptr_d = ptr_q + PTR_STEP;
          end
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_d = 1'b0;
          cnt_d = CNT_ZERO;
          if (!mack_q) begin
            tx_d  = rb.rd_data;
            oe_d  = ~rb.rd_data[7];
            rd_en = 1'b1;
          end else begin
            state_d = ST_SKIP;
            oe_d    = 1'b0;
          end
        end else if (cnt_q == BYTE_BITS) begin
          ack_d = 1'b1;
          oe_d  = 1'b0;
        end else if (cnt_q != CNT_ZERO) begin
          tx_d = {tx_q[6:0], 1'b0};
          oe_d = ~tx_q[6];
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q   <= CNT_ZERO;
      ack_q   <= 1'b0;
      sr_q    <= RD_NONE;
      tx_q    <= RD_NONE;
      ptr_q   <= RD_NONE;
      hs_q    <= 1'b0;
      oe_q    <= 1'b0;
      mack_q  <= 1'b1;
      scl_p_q <= PIN_IDLE;
      sda_p_q <= PIN_IDLE;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ack_q   <= ack_d;
      sr_q    <= sr_d;
      tx_q    <= tx_d;
      ptr_q   <= ptr_d;
      hs_q    <= hs_d;
      oe_q    <= oe_d;
      mack_q  <= mack_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end

  assign rb.addr    = ptr_q;
  assign rb.wr_en   = wr_en;
  assign rb.wr_data = sr_q;
  assign rb.rd_en   = rd_en;

  // only the data line is ever driven; clock line has no driver
  assign sda_o     = SDA_DRIVE_LVL;
  assign sda_oe    = oe_q;
  assign hs_filter = hs_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  stop_filter_a: assert property (stop_c |=> !hs_q)
    else $error("filters not slow after stop");
  rstart_keep_a: assert property (
    start_c && !stop_c |=> hs_q == $past(hs_q))
    else $error("repeated start changed filter setting");
  hs_code_a: assert property (
    state_q == ST_ADDR && byte_fall && is_hs_code
    |=> hs_q && !sda_oe ##1 !sda_oe)
    else $error("master code not nacked or filters not fast");
  addr_ack_a: assert property (
    state_q == ST_ADDR && byte_fall && adr_match && !is_gcall
    |=> sda_oe)
    else $error("own address not acknowledged");
  gcall_nack_a: assert property (
    state_q == ST_ADDR && byte_fall && is_gcall |=> !sda_oe)
    else $error("general call acknowledged");
  ptr_ack_a: assert property (
    state_q == ST_PTR && byte_fall |=> sda_oe && state_q == ST_PTR)
    else $error("pointer byte not acknowledged");
  wr_commit_a: assert property (
    state_q == ST_WDAT && ack_end
    |-> rb.wr_en && rb.wr_data == sr_q
    ##1 ptr_q == $past(ptr_q) + PTR_STEP)
    else $error("write byte not committed or pointer not advanced");
  stop_ptr_a: assert property (stop_c |=> ptr_q == $past(ptr_q))
    else $error("stop changed register pointer");
  rd_load_a: assert property (
    state_q == ST_ADDR && ack_end && oe_q && sr_q[0]
    |-> rd_en ##1 tx_q == $past(rb.rd_data) && state_q == ST_RDAT)
    else $error("read byte not loaded from pointed register");
  mack_next_a: assert property (
    state_q == ST_RDAT && scl_rise && ack_q && !sda_f && !start_c
    |=> ptr_q == $past(ptr_q) + PTR_STEP)
    else $error("controller ack did not advance pointer");
  nack_end_a: assert property (
    state_q == ST_RDAT && ack_end && mack_q && !start_c && !stop_c
    |=> state_q == ST_SKIP && !sda_oe [*2])
    else $error("read not ended on controller nack");

  write_seen_c: cover property (
    state_q == ST_WDAT && ack_end ##[1:200] state_q == ST_WDAT && ack_end);
  read_seen_c: cover property (
    state_q == ST_RDAT && ack_end && !mack_q);
  hs_seen_c: cover property (hs_q ##[1:1000] start_c && hs_q);
endmodule

// *** rtl/pri_regbank.sv ***
// register bank: configuration, read-to-clear event flags, status
`timescale 1ns/10ps
module pri_regbank
  import pri_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A  // value arbitrary
) (
  input  wire logic                mclk,
  input  wire logic                srst,
  pri_reg_if.bank                  rb,
  input  wire logic [RC_N*8-1:0]   ev_flags,
  input  wire logic [23:0]         st_in,
  output logic      [RW_N*8-1:0]   cfg_out
);
  logic [7:0] cfg_q  [RW_N];
  logic [7:0] flag_q [RC_N];
  logic [7:0] ro_val [RO_N];
  logic [4:0] rws;
  logic [2:0] rcs;
  logic [2:0] ros;

  assign rws = rw_slot(rb.addr);
  assign rcs = small_slot(rb.addr, {RC_OFS[3], RC_OFS[2], RC_OFS[1],
                                    RC_OFS[0]});
  assign ros = small_slot(rb.addr, {RO_OFS[3], RO_OFS[2], RO_OFS[1],
                                    RO_OFS[0]});

  for (genvar i = 0; i < RW_N; i++) begin : g_rw
    logic hit;
    assign hit = rb.wr_en && rws[4] && (rws[3:0] == 4'(i));
    always_ff @(posedge mclk) begin
      if (srst) begin
        cfg_q[i] <= RW_RST;
      end else if (hit) begin
        cfg_q[i] <= rb.wr_data;
      end
    end
    assign cfg_out[i*8 +: 8] = cfg_q[i];
  end

  for (genvar i = 0; i < RC_N; i++) begin : g_rc
    logic clr;
    assign clr = rb.rd_en && rcs[2] && (rcs[1:0] == 2'(i));
    // a new event in the clearing cycle survives
    always_ff @(posedge mclk) begin
      if (srst) begin
        flag_q[i] <= RW_RST;
      end else begin
        flag_q[i] <= (clr ? RW_RST : flag_q[i]) | ev_flags[i*8 +: 8];
      end
    end
  end

  for (genvar i = 0; i < RO_N - 1; i++) begin : g_ro
    assign ro_val[i] = st_in[i*8 +: 8];
  end
  assign ro_val[RO_N-1] = CHIP_ID;

  assign rb.rd_data = rws[4] ? cfg_q[rws[3:0]] :
                      rcs[2] ? flag_q[rcs[1:0]] :
                      ros[2] ? ro_val[ros[1:0]] : RD_NONE;
endmodule

// *** rtl/pri_sync.sv ***
// two-flop synchroniser with selectable spike filter per pin
`timescale 1ns/10ps
module pri_sync
  import pri_pkg::*;
#(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d_in,
  input  wire logic         hs_sel,
  output logic      [W-1:0] d_out
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [3:0]   need;

  assign need = hs_sel ? SPK_HS_CYC : SPK_LS_CYC;

  always_ff @(posedge mclk) begin
    if (srst) begin
      s1_q <= {W{PIN_IDLE}};
      s2_q <= {W{PIN_IDLE}};
    end else begin
      s1_q <= d_in;
      s2_q <= s1_q;
    end
  end

  for (genvar i = 0; i < W; i++) begin : g_filt
    logic [3:0] run_q;
    logic       out_q;
    logic       settle;
    // new level must persist for need samples before it is passed on
    assign settle = (s2_q[i] != out_q) && ((run_q + 4'h1) >= need);
    always_ff @(posedge mclk) begin
      if (srst) begin
        run_q <= CNT_ZERO;
        out_q <= PIN_IDLE;
      end else if (s2_q[i] == out_q || settle) begin
        run_q <= CNT_ZERO;
        out_q <= s2_q[i];
      end else begin
        run_q <= run_q + 4'h1;
      end
    end
    assign d_out[i] = out_q;
  end
endmodule

// *** testbench/pmic_i2c_register_access_test.sv ***
// self-checking bench for the two-wire register port
`timescale 1ns/10ps
module pmic_i2c_register_access_test
  import pri_pkg::*;
;
  localparam logic [7:0] ID_VAL = 8'hA5;  // value arbitrary
  logic                mclk, srst, scl, host_oe, addr_sel;
  logic                sda_o, sda_oe, hs_filter;
  logic [RC_N*8-1:0]   ev_flags;
  logic [23:0]         st_in;
  logic [RW_N*8-1:0]   cfg_out;
  logic [6:0]          dev;
  int                  bad_count, comparisons;
  wire                 sda;

  assign sda = ((sda_oe & ~sda_o) | host_oe) ? 1'b0 : 1'b1;

  pri_i2c_target #(.CHIP_ID(ID_VAL)) uut (
    .mclk(mclk), .srst(srst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .hs_filter(hs_filter),
    .ev_flags(ev_flags), .st_in(st_in), .cfg_out(cfg_out));

  pri_host_model p (.scl(scl), .host_oe(host_oe), .sda(sda));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    if (bad_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic snd(input logic [7:0] b, input logic ea);
    logic [7:0] r;
    logic       a;
    p.xfer(b, 1'b0, r, a);
    chk({7'h00, a}, {7'h00, ea});
  endtask

  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$],
                    input logic lack);
    logic [7:0] r;
    logic       a;
    p.start();
    snd({dev, 1'b0}, 1'b0);
    snd(ptr, 1'b0);
    foreach (d[i]) begin
      p.xfer(d[i], lack && (i == d.size() - 1), r, a);
      if (!lack || i < d.size() - 1) chk({7'h00, a}, 8'h00);
    end
    p.stop();
  endtask

  task automatic rd(input logic ptr_ph, input logic [7:0] ptr,
                    input logic [7:0] e[$]);
    logic [7:0] r;
    logic       a;
    p.start();
    if (ptr_ph) begin
      snd({dev, 1'b0}, 1'b0);
      snd(ptr, 1'b0);
      p.rstart();
    end
    snd({dev, 1'b1}, 1'b0);
    foreach (e[i]) begin
      p.xfer(8'hFF, i < e.size() - 1, r, a);
      chk(r, e[i]);
    end
    p.stop();
  endtask

  task automatic do_reset(input logic strap);
    srst     = 1'b1;
    addr_sel = strap;
    repeat (8) @(negedge mclk);
    srst = 1'b0;
    repeat (6) @(negedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // hang guard
  initial begin
    #1500000;
    bad_count++;
    end_sim();
  end

  initial begin
    bad_count   = 0;
    comparisons = 0;
    ev_flags    = '0;
    st_in       = 24'h3C_C3_96;
    dev         = TGT_ADDR_STRAP1;
    do_reset(1'b1);
    chk({6'h00, hs_filter, sda_oe}, 8'h00);
    chk(cfg_out[7:0], RW_RST);
    // sequential write, controller acks the last byte
    wr(8'h07, {8'h11, 8'h22, 8'h33}, 1'b1);
    @(negedge mclk);
    for (int i = 0; i < 3; i++) begin
      chk(cfg_out[i*8 +: 8], 8'(8'h11 * (i + 1)));
    end
    rd(1'b1, 8'h07, {8'h11, 8'h22, 8'h33});
    rd(1'b0, 8'h00, {8'h33});
    // unmapped and read-only places
    wr(8'h30, {8'hAA, 8'h55}, 1'b0);
    wr(8'h02, {8'hFF}, 1'b0);
    rd(1'b1, 8'h30, {8'h00, 8'h00});
    rd(1'b1, 8'h02, {8'h96, 8'hC3});
    rd(1'b1, 8'h14, {ID_VAL});
    // event flag set by a pulse, cleared by its read
    @(negedge mclk);
    ev_flags = 32'h0000_8100;
    @(negedge mclk);
    ev_flags = '0;
    rd(1'b1, 8'h01, {8'h81});
    rd(1'b0, 8'h00, {8'h00});
    // foreign address, general call
    p.start();
    snd(8'h92, 1'b1);
    p.stop();
    p.start();
    snd(GCALL_ADDR, 1'b1);
    p.stop();
    // master codes, write in fast mode across a repeated start
    for (int m = 0; m < 2; m++) begin
      p.start();
      snd(m[0] ? 8'h0F : 8'h08, 1'b1);
      chk({7'h00, hs_filter}, 8'h01);
      p.rstart();
      snd({dev, 1'b0}, 1'b0);
      snd(8'h20, 1'b0);
      snd(8'hC0 | 8'(m), 1'b0);
      chk({7'h00, hs_filter}, 8'h01);
      p.stop();
      repeat (10) @(negedge mclk);
      chk({7'h00, hs_filter}, 8'h00);
      chk(cfg_out[71:64], 8'hC0 | 8'(m));
    end
    // second strap value
    do_reset(1'b0);
    dev = TGT_ADDR_STRAP0;
    p.start();
    snd({TGT_ADDR_STRAP1, 1'b0}, 1'b1);
    p.stop();
    rd(1'b1, 8'h07, {RW_RST});
    end_sim();
  end
endmodule

// *** testbench/pri_host_model.sv ***
// bus controller model driving the two-wire link of the register port
`timescale 1ns/10ps
module pri_host_model (
  output logic      scl,
  output logic      host_oe,
  input  wire logic sda
);
  // scl period 160 ns, long low phase to cover the device's input delay
  localparam int PH  = 160;
  localparam int LO  = 120;
  localparam int HI  = PH - LO;
  localparam int DLY = 40;

  initial begin
    scl     = 1'b1;
    host_oe = 1'b0;
  end

  // data moves early in the low phase, lands inside after the fall
  task automatic bit_io(input logic b, output logic r);
    #DLY host_oe = ~b;
    #(LO - DLY) scl = 1'b1;
    #(HI / 2) r = sda;
    #(HI / 2) scl = 1'b0;
  endtask

  task automatic start();
    #PH host_oe = 1'b1;
    #PH scl = 1'b0;
  endtask

  task automatic rstart();
    #DLY host_oe = 1'b0;
    #(LO - DLY) scl = 1'b1;
    #PH host_oe = 1'b1;
    #PH scl = 1'b0;
  endtask

  // scl then stands high until the next frame
  task automatic stop();
    #DLY host_oe = 1'b1;
    #(LO - DLY) scl = 1'b1;
    #PH host_oe = 1'b0;
    #PH;
  endtask

  // eight bits msb first, then the ninth slot, driven low when m_ack
  task automatic xfer(input logic [7:0] d, input logic m_ack,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(~m_ack, a);
  endtask
endmodule
